// ===== ssx_pkg.sv
// Constants, flag layout and interrupt layout for the synchronous serial unit.
package ssx_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_HALF_NS = 32;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [DIV_W-1:0] SCK_HALF_TERM = DIV_W'(SCK_HALF_CYC - 1);
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic rx_buffer_full_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic tx_end_flag;
  } ssx_flags_t;

  localparam ssx_flags_t FLAGS_RST = 6'h20;
  localparam ssx_flags_t FLAGS_NONE = 6'h00;

  typedef struct packed {
    logic rx_error_irq;
    logic rx_full_irq;
    logic tx_empty_irq;
    logic tx_end_irq;
  } ssx_irq_t;

  localparam ssx_irq_t IRQ_NONE = 4'h0;

endpackage

// ===== ssx_unit.sv
// Synchronous mode serial transmitter and receiver with status flags and interrupt lines.
`timescale 1ns/1ps
// Functional notes
// - Transmit disable sets buffer empty, resets shifter.
// - Receive disable keeps receive flags and buffer.
// - Empty clear loads shifter, sets empty, starts.
// - Internal clock gives eight pulses per character.
// - Eight data bits, least significant first.
// - Refilled buffer at last bit continues seamlessly.
// - Empty at last bit sets end, holds line.
// - Serial clock stays constant after transmission.
// - Full character moves to buffer, sets full.
// - Full never set while framing/parity error.
// - Any receive error blocks transmit and receive.
// - Transfer controller access clears matching flag.
// - Four gated interrupt lines, independent outputs.
// - Empty and end requests follow their flags.
// - Full and error requests gated by receive interrupt enable.
// - Only full and empty trigger transfer controller.
// - Priority: error, full, empty, end.
// - End clears with empty; empty outranks end.
// - Drive on falling edge, sample on rising.
// - Internal clock idles high; receive-only runs on.
module ssx_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic transmit_enable,
  input wire logic rx_on,
  input wire logic clock_internal,
  input wire logic tx_empty_irq_enable,
  input wire logic rx_irq_enable,
  input wire logic tx_end_irq_enable,
  input wire logic tx_buffer_write,
  input wire logic [7:0] tx_buffer_wdata,
  input wire logic status_read,
  input wire logic status_write,
  input wire ssx_pkg::ssx_flags_t status_wdata,
  input wire logic xfer_tx_write,
  input wire logic [7:0] xfer_tx_wdata,
  input wire logic xfer_rx_read,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  output logic serial_out,
  output ssx_pkg::ssx_flags_t status,
  output logic [7:0] rx_buffer,
  output ssx_pkg::ssx_irq_t irq,
  output ssx_pkg::ssx_irq_t irq_top,
  output logic xfer_tx_trigger,
  output logic xfer_rx_trigger
);

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_DRAIN} ssx_tx_state_t;

  ssx_tx_state_t tx_state_reg, tx_state_next;
  ssx_pkg::ssx_flags_t flags_reg, flags_next, arm_reg, arm_next, set_v, clr_v;
  ssx_pkg::ssx_irq_t irq_reg, irq_next, top_reg, top_next;
  logic [7:0] tdr_reg, tdr_next, tsr_reg, tsr_next, rsr_reg, rsr_next, rdr_reg, rdr_next;
  logic [2:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic [2:0] sck_sync_reg, rxd_sync_reg;
  logic sck_lvl_reg, sck_lvl_next, rxd_lvl_reg, rxd_lvl_next;
  logic [ssx_pkg::DIV_W-1:0] div_reg, div_next;
  logic sck_reg, sck_next, out_reg, out_next, oe_n_reg, oe_n_next;
  logic xtx_reg, xrx_reg;
  logic err, rx_only, clk_run, tick, fall_ev, rise_ev, tx_start, bit7_fall;
  logic [7:0] rsr_shift;

  // Both pins pass three flops; only the second and third are compared.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sck_sync_reg <= ssx_pkg::SYNC_RST;
      rxd_sync_reg <= ssx_pkg::SYNC_RST;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_in};
      rxd_sync_reg <= {rxd_sync_reg[1:0], serial_in};
    end
  end

  assign err = flags_reg.overrun_error_flag | flags_reg.framing_error_flag | flags_reg.parity_error_flag;
  // Receive-only with internal clock keeps clocking until overrun or receive off.
  assign rx_only = rx_on & ~transmit_enable & ~err & clock_internal;
  assign clk_run = (tx_state_reg != TX_IDLE) | rx_only;
  assign tick = clock_internal & clk_run & (div_reg == ssx_pkg::SCK_HALF_TERM);
  assign tx_start = transmit_enable & ~flags_reg.tx_buffer_empty_flag & ~err;
  assign bit7_fall = (tx_state_reg == TX_SHIFT) & fall_ev & (tx_cnt_reg == ssx_pkg::BIT_LAST);
  assign rsr_shift = {rxd_lvl_reg, rsr_reg[7:1]};

  always_comb
  begin
    sck_lvl_next = sck_lvl_reg;
    rxd_lvl_next = rxd_lvl_reg;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    if (sck_sync_reg[1] == sck_sync_reg[2])
    begin
      sck_lvl_next = sck_sync_reg[2];
    end
    if (rxd_sync_reg[1] == rxd_sync_reg[2])
    begin
      rxd_lvl_next = rxd_sync_reg[2];
    end
    if (clock_internal)
    begin
      fall_ev = tick & sck_reg;
      rise_ev = tick & ~sck_reg;
    end
    else
    begin
      fall_ev = sck_lvl_reg & ~sck_lvl_next;
      rise_ev = ~sck_lvl_reg & sck_lvl_next;
    end
  end

  // Internal clock divider; stopping it snaps the line back high.
  always_comb
  begin
    div_next = ssx_pkg::DIV_RST;
    sck_next = 1'b1;
    oe_n_next = ~clock_internal;
    if (clock_internal & clk_run)
    begin
      div_next = tick ? ssx_pkg::DIV_RST : div_reg + 1'b1;
      sck_next = tick ? ~sck_reg : sck_reg;
    end
  end

  always_comb
  begin
    tx_state_next = tx_state_reg;
    tsr_next = tsr_reg;
    tx_cnt_next = tx_cnt_reg;
    out_next = out_reg;
    tdr_next = tdr_reg;
    rsr_next = rsr_reg;
    rdr_next = rdr_reg;
    rx_cnt_next = rx_cnt_reg;
    set_v = ssx_pkg::FLAGS_NONE;
    clr_v = ssx_pkg::FLAGS_NONE;
    if (tx_buffer_write)
    begin
      tdr_next = tx_buffer_wdata;
    end
    if (xfer_tx_write)
    begin
      tdr_next = xfer_tx_wdata;
      clr_v.tx_buffer_empty_flag = 1'b1;
    end
    if (xfer_rx_read)
    begin
      clr_v.rx_buffer_full_flag = 1'b1;
    end
    if (status_write)
    begin
      clr_v = ssx_pkg::ssx_flags_t'(clr_v | (arm_reg & ~status_wdata));
    end
    clr_v.tx_end_flag = clr_v.tx_end_flag | clr_v.tx_buffer_empty_flag;
    case (tx_state_reg)
      TX_IDLE:
      begin
        if (tx_start)
        begin
          tsr_next = tdr_reg;
          set_v.tx_buffer_empty_flag = 1'b1;
          tx_cnt_next = ssx_pkg::BIT_FIRST;
          tx_state_next = TX_SHIFT;
        end
      end
      TX_SHIFT:
      begin
        if (fall_ev)
        begin
          out_next = tsr_reg[0];
          tsr_next = {1'b0, tsr_reg[7:1]};
          tx_cnt_next = tx_cnt_reg + 1'b1;
          if (tx_cnt_reg == ssx_pkg::BIT_LAST)
          begin
            if (tx_start)
            begin
              tsr_next = tdr_reg;
              set_v.tx_buffer_empty_flag = 1'b1;
            end
            else
            begin
              set_v.tx_end_flag = 1'b1;
              tx_state_next = TX_DRAIN;
            end
          end
        end
      end
      TX_DRAIN:
      begin
        if (rise_ev)
        begin
          tx_state_next = TX_IDLE;
        end
      end
      default:
      begin
        tx_state_next = TX_IDLE;
      end
    endcase
    if (!transmit_enable)
    begin
      tx_state_next = TX_IDLE;
      tsr_next = ssx_pkg::SHIFT_RST;
      tx_cnt_next = ssx_pkg::BIT_FIRST;
      set_v.tx_buffer_empty_flag = 1'b1;
    end
    // Receive off only stops the shifter; flags and buffer are untouched.
    if (!rx_on || err)
    begin
      rx_cnt_next = ssx_pkg::BIT_FIRST;
    end
    else if (rise_ev)
    begin
      rsr_next = rsr_shift;
      rx_cnt_next = rx_cnt_reg + 1'b1;
      if (rx_cnt_reg == ssx_pkg::BIT_LAST)
      begin
        if (flags_reg.rx_buffer_full_flag)
        begin
          set_v.overrun_error_flag = 1'b1;
        end
        else if (!flags_reg.framing_error_flag && !flags_reg.parity_error_flag)
        begin
          rdr_next = rsr_shift;
          set_v.rx_buffer_full_flag = 1'b1;
        end
      end
    end
    // A flag set in the same cycle as its clear stays set.
    flags_next = ssx_pkg::ssx_flags_t'((flags_reg & ~clr_v) | set_v);
    arm_next = status_write ? ssx_pkg::FLAGS_NONE : arm_reg;
    if (status_read)
    begin
      arm_next = ssx_pkg::ssx_flags_t'(arm_reg | flags_reg);
    end
  end

  always_comb
  begin
    irq_next.tx_empty_irq = flags_next.tx_buffer_empty_flag & tx_empty_irq_enable;
    irq_next.tx_end_irq = flags_next.tx_end_flag & tx_end_irq_enable;
    irq_next.rx_full_irq = flags_next.rx_buffer_full_flag & rx_irq_enable;
    irq_next.rx_error_irq = (flags_next.overrun_error_flag | flags_next.framing_error_flag | flags_next.parity_error_flag) & rx_irq_enable;
    top_next = ssx_pkg::IRQ_NONE;
    if (irq_next.rx_error_irq)
    begin
      top_next.rx_error_irq = 1'b1;
    end
    else if (irq_next.rx_full_irq)
    begin
      top_next.rx_full_irq = 1'b1;
    end
    else if (irq_next.tx_empty_irq)
    begin
      top_next.tx_empty_irq = 1'b1;
    end
    else if (irq_next.tx_end_irq)
    begin
      top_next.tx_end_irq = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= TX_IDLE;
      flags_reg <= ssx_pkg::FLAGS_RST;
      arm_reg <= ssx_pkg::FLAGS_NONE;
      irq_reg <= ssx_pkg::IRQ_NONE;
      top_reg <= ssx_pkg::IRQ_NONE;
      tdr_reg <= ssx_pkg::BUF_RST;
      tsr_reg <= ssx_pkg::SHIFT_RST;
      rsr_reg <= ssx_pkg::SHIFT_RST;
      rdr_reg <= ssx_pkg::BUF_RST;
      tx_cnt_reg <= ssx_pkg::BIT_FIRST;
      rx_cnt_reg <= ssx_pkg::BIT_FIRST;
      sck_lvl_reg <= 1'b1;
      rxd_lvl_reg <= 1'b1;
      div_reg <= ssx_pkg::DIV_RST;
      sck_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      out_reg <= 1'b1;
      xtx_reg <= 1'b0;
      xrx_reg <= 1'b0;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      flags_reg <= flags_next;
      arm_reg <= arm_next;
      irq_reg <= irq_next;
      top_reg <= top_next;
      tdr_reg <= tdr_next;
      tsr_reg <= tsr_next;
      rsr_reg <= rsr_next;
      rdr_reg <= rdr_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      sck_lvl_reg <= sck_lvl_next;
      rxd_lvl_reg <= rxd_lvl_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      oe_n_reg <= oe_n_next;
      out_reg <= out_next;
      xtx_reg <= irq_next.tx_empty_irq;
      xrx_reg <= irq_next.rx_full_irq;
    end
  end

  assign serial_clock_out = sck_reg;
  assign serial_clock_oe_n = oe_n_reg;
  assign serial_out = out_reg;
  assign status = flags_reg;
  assign rx_buffer = rdr_reg;
  assign irq = irq_reg;
  assign irq_top = top_reg;
  assign xfer_tx_trigger = xtx_reg;
  assign xfer_rx_trigger = xrx_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_bit;
    bit7_fall;
  endsequence

  property p_te_off;
    !transmit_enable |=> flags_reg.tx_buffer_empty_flag && tx_state_reg == TX_IDLE && tsr_reg == 8'h00;
  endproperty
  a_te_off: assert property (p_te_off) else $error("transmit disable did not reset");

  property p_re_off;
    !rx_on && !status_write && !xfer_rx_read |=> $stable(rdr_reg) && $stable(flags_reg.rx_buffer_full_flag);
  endproperty
  a_re_off: assert property (p_re_off) else $error("receive disable changed state");

  property p_load;
    tx_state_reg == TX_IDLE && tx_start |=> tx_state_reg == TX_SHIFT && flags_reg.tx_buffer_empty_flag;
  endproperty
  a_load: assert property (p_load) else $error("buffer not loaded into shifter");

  property p_continue;
    s_last_bit ##0 tx_start |=> tx_state_reg == TX_SHIFT && tsr_reg == $past(tdr_reg);
  endproperty
  a_continue: assert property (p_continue) else $error("no seamless next frame");

  property p_end;
    s_last_bit ##0 !tx_start |=> flags_reg.tx_end_flag && tx_state_reg == TX_DRAIN ##1 $stable(out_reg);
  endproperty
  a_end: assert property (p_end) else $error("transmit end not flagged");

  property p_sck_idle;
    clock_internal && !clk_run |=> serial_clock_out && !serial_clock_oe_n;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle high");

  property p_full_guard;
    $rose(flags_reg.rx_buffer_full_flag) |-> !$past(flags_reg.framing_error_flag) && !$past(flags_reg.parity_error_flag);
  endproperty
  a_full_guard: assert property (p_full_guard) else $error("full set under error");

  property p_lockout;
    err |-> ##1 !$rose(tx_state_reg == TX_SHIFT) && rx_cnt_reg == 3'h0;
  endproperty
  a_lockout: assert property (p_lockout) else $error("transfer under receive error");

  property p_end_irq;
    flags_reg.tx_end_flag && tx_end_irq_enable && !clr_v.tx_end_flag |=> irq.tx_end_irq;
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("end request missing");

  property p_tx_end_flag_clr;
    $fell(flags_reg.tx_buffer_empty_flag) |-> !flags_reg.tx_end_flag;
  endproperty
  a_tx_end_flag_clr: assert property (p_tx_end_flag_clr) else $error("end flag outlived empty flag");

  property p_write_one;
    status_write && status_wdata.overrun_error_flag && !xfer_rx_read |=> flags_reg.overrun_error_flag >= $past(flags_reg.overrun_error_flag);
  endproperty
  a_write_one: assert property (p_write_one) else $error("write of one cleared a flag");

endmodule

// ===== ssx_peer.sv
// Behavioural synchronous serial partner sharing the serial clock with the unit.
`timescale 1ns/1ps
module ssx_peer (
  input wire logic ext,
  input wire logic go,
  input wire logic clr,
  input wire logic [15:0] word,
  input wire logic sck_dev,
  input wire logic data_dev,
  output logic sck_ext,
  output logic data_out,
  output logic [15:0] cap,
  output int cnt
);
  logic sck;
  assign sck = ext ? sck_ext : sck_dev;
  initial
  begin
    sck_ext = 1'b1;
    data_out = 1'b1;
    cap = 16'h0000;
    cnt = 0;
  end
  // The external clock stands still between frames and has no phase tie to clk.
  always @(posedge go)
  begin
    #2;
    repeat (8)
    begin
      #32 sck_ext = 1'b0;
      #32 sck_ext = 1'b1;
    end
  end
  // Data changes at falls and is taken at rises; past its word the line toggles.
  always @(negedge sck)
    data_out = (cnt < 16) ? word[cnt[3:0]] : ~data_out;
  always @(posedge sck)
  begin
    cap = {data_dev, cap[15:1]};
    cnt = cnt + 1;
  end
  always @(posedge clr)
    cnt = 0;
endmodule

// ===== sync_serial_txrx_irq_tb.sv
// Self-checking bench for the synchronous serial unit.
`timescale 1ns/1ps
module sync_serial_txrx_irq_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic transmit_enable = 1'b1;
  logic rx_on = 1'b1;
  logic clock_internal = 1'b1;
  logic tx_empty_irq_enable = 1'b0;
  logic rx_irq_enable = 1'b1;
  logic tx_end_irq_enable = 1'b1;
  logic tx_buffer_write = 1'b0;
  logic [7:0] tx_buffer_wdata = 8'h00;
  logic status_read = 1'b0;
  logic status_write = 1'b0;
  ssx_pkg::ssx_flags_t status_wdata = 6'h3F;
  logic xfer_tx_write = 1'b0;
  logic [7:0] xfer_tx_wdata = 8'h00;
  logic xfer_rx_read = 1'b0;
  logic serial_clock_in, serial_in, serial_clock_out, serial_clock_oe_n, serial_out;
  ssx_pkg::ssx_flags_t status;
  logic [7:0] rx_buffer;
  ssx_pkg::ssx_irq_t irq, irq_top;
  logic xfer_tx_trigger, xfer_rx_trigger;
  logic go = 1'b0;
  logic clr = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [15:0] cap;
  int cnt;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  ssx_unit ssx_unit_inst (
    .clk(clk),
    .rst_n(rst_n),
    .transmit_enable(transmit_enable),
    .rx_on(rx_on),
    .clock_internal(clock_internal),
    .tx_empty_irq_enable(tx_empty_irq_enable),
    .rx_irq_enable(rx_irq_enable),
    .tx_end_irq_enable(tx_end_irq_enable),
    .tx_buffer_write(tx_buffer_write),
    .tx_buffer_wdata(tx_buffer_wdata),
    .status_read(status_read),
    .status_write(status_write),
    .status_wdata(status_wdata),
    .xfer_tx_write(xfer_tx_write),
    .xfer_tx_wdata(xfer_tx_wdata),
    .xfer_rx_read(xfer_rx_read),
    .serial_clock_in(serial_clock_in),
    .serial_in(serial_in),
    .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n),
    .serial_out(serial_out),
    .status(status),
    .rx_buffer(rx_buffer),
    .irq(irq),
    .irq_top(irq_top),
    .xfer_tx_trigger(xfer_tx_trigger),
    .xfer_rx_trigger(xfer_rx_trigger)
  );
  ssx_peer ssx_peer_inst (
    .ext(~clock_internal),
    .go(go),
    .clr(clr),
    .word(word),
    .sck_dev(serial_clock_out),
    .data_dev(serial_out),
    .sck_ext(serial_clock_in),
    .data_out(serial_in),
    .cap(cap),
    .cnt(cnt)
  );
  always #2 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A status write clears only flags read as set and written zero; clearing empty also clears end.
  task automatic clear_flags(input ssx_pkg::ssx_flags_t w);
    status_read = 1'b1;
    tick(1);
    status_read = 1'b0;
    status_write = 1'b1;
    status_wdata = w;
    tick(1);
    status_write = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    tx_buffer_write = 1'b1;
    tx_buffer_wdata = b;
    tick(1);
    tx_buffer_write = 1'b0;
    clear_flags(6'h1F);
  endtask
  task automatic restart;
    xfer_rx_read = 1'b1;
    clr = 1'b1;
    tick(1);
    xfer_rx_read = 1'b0;
    clr = 1'b0;
    tick(1);
  endtask
  task automatic wait_tx_end_flag;
    for (int i = 0; i < 600 && status.tx_end_flag !== 1'b1; i++)
      tick(1);
    chk("tx_end_flag", 16'h1, status.tx_end_flag);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  initial
  begin
    tick(15);
    // The pin settling from unknown counts as a rising clock in the partner; clear that count.
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    rst_n = 1'b1;
    chk("status", 16'h20, status);
    chk("pins", 16'h3, {serial_clock_out, serial_out});
    tick(2);
    chk("irq", 16'h0, irq);
    tx_empty_irq_enable = 1'b1;
    tick(2);
    chk("irq", 16'h2, irq);
    chk("tx_trigger", 16'h1, xfer_tx_trigger);
    word = 16'h003C;
    send(8'hA5);
    wait_tx_end_flag;
    tick(40);
    chk("peer_bits", 16'hA5, cap[15:8]);
    chk("pulses", 16'h8, cnt);
    chk("line_idle", 16'h3, {serial_clock_out, serial_out});
    chk("rx_buffer", 16'h3C, rx_buffer);
    chk("irq", 16'h7, irq);
    chk("irq_top", 16'h4, irq_top);
    chk("rx_trigger", 16'h1, xfer_rx_trigger);
    restart;
    chk("rx_full", 16'h0, status.rx_buffer_full_flag);
    chk("irq_top", 16'h2, irq_top);
    word = 16'hC35A;
    send(8'h81);
    tick(4);
    xfer_tx_write = 1'b1;
    xfer_tx_wdata = 8'h7E;
    tick(1);
    xfer_tx_write = 1'b0;
    chk("tx_empty", 16'h0, status.tx_buffer_empty_flag);
    wait_tx_end_flag;
    tick(40);
    chk("peer_bits", 16'h7E81, cap);
    chk("pulses", 16'h10, cnt);
    chk("flags", 16'h39, status);
    chk("rx_buffer", 16'h5A, rx_buffer);
    chk("irq_top", 16'h8, irq_top);
    rx_irq_enable = 1'b0;
    tick(2);
    chk("irq", 16'h3, irq);
    rx_irq_enable = 1'b1;
    restart;
    word = 16'h00E7;
    send(8'h99);
    tick(60);
    chk("pulses", 16'h0, cnt);
    chk("tx_empty", 16'h0, status.tx_buffer_empty_flag);
    clear_flags(6'h3F);
    tick(1);
    status_write = 1'b1;
    status_wdata = 6'h37;
    tick(1);
    status_write = 1'b0;
    chk("overrun", 16'h1, status.overrun_error_flag);
    clear_flags(6'h37);
    chk("overrun", 16'h0, status.overrun_error_flag);
    wait_tx_end_flag;
    tick(40);
    chk("peer_bits", 16'h99, cap[15:8]);
    chk("rx_buffer", 16'hE7, rx_buffer);
    send(8'hF0);
    tick(30);
    transmit_enable = 1'b0;
    rx_on = 1'b0;
    tick(2);
    chk("tx_empty", 16'h1, status.tx_buffer_empty_flag);
    chk("rx_state", 16'h1E7, {status.rx_buffer_full_flag, rx_buffer});
    tick(20);
    chk("sck_idle", 16'h1, serial_clock_out);
    chk("err_flags", 16'h0, {status.overrun_error_flag, status.framing_error_flag, status.parity_error_flag});
    clock_internal = 1'b0;
    tick(1);
    transmit_enable = 1'b1;
    rx_on = 1'b1;
    restart;
    word = 16'h0096;
    send(8'h6C);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    wait_tx_end_flag;
    tick(40);
    chk("peer_bits", 16'h6C, cap[15:8]);
    chk("rx_buffer", 16'h96, rx_buffer);
    chk("sck_oe_n", 16'h1, serial_clock_oe_n);
    transmit_enable = 1'b0;
    rx_on = 1'b0;
    tick(1);
    clock_internal = 1'b1;
    restart;
    // Receive-only on the internal clock runs until the second character overruns.
    word = 16'h5AC3;
    rx_on = 1'b1;
    tick(400);
    chk("rx_only_buf", 16'hC3, rx_buffer);
    chk("rx_only_flags", 16'h3, {status.rx_buffer_full_flag, status.overrun_error_flag});
    chk("pulses", 16'h10, cnt);
    chk("sck_idle", 16'h1, serial_clock_out);
    tally_and_finish;
  end
endmodule
